// ==== tce_exc_unit.sv ====
// How it works
// RULE1: a mapped reference with no tlb match raises a refill fault
// RULE2: refill vector is 0x000 for 32-bit space, 0x080 for 64-bit space
// RULE3: dedicated refill vectors only while the exception level bit is 0
// RULE4: refill with exception level bit set goes through the common vector
// RULE5: refill sets load/fetch miss or store miss code by access type
// RULE6: tlb faults load the failing address into vaddr, both pointers, tag
// RULE7: tag staging also takes the current address-space tag
// RULE8: return pc is the instruction, or its branch with delay-slot flag set
// RULE9: match on an entry with valid clear raises invalid via common vector
// RULE10: store to an entry with dirty clear raises write-protect fault
// RULE11: cache check error uses vector 0x100 with an uncached base
// RULE12: cache fault sets its code, records type, way and address
// RULE13: icache line invalidated, single data error fixed, double left to software
// RULE14: a bus error completion response raises a bus fault
// RULE15: bus fault uses common vector, fetch or data bus code
// RULE16: the common vector sits at offset 0x180
// RULE17: codes are write-protect 1, load 2, store 3, fetch bus 6, data bus 7
// RULE18: only the highest priority fault is reported, the instruction is killed
//
// The register addresses and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
module tce_exc_unit (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // instruction check request
    input wire logic chkValid,
    input wire logic [63:0] chkPc,
    input wire logic chkInDelaySlot,
    input wire logic [63:0] chkBranchPc,
    input wire logic chkIsFetch,
    input wire logic chkIsStore,
    input wire logic [63:0] chkVaddr,
    input wire logic chkAddr64,
    input wire logic chkMapped,
    input wire logic [7:0] curAsid,
    // tlb lookup result
    input wire logic tlbHit,
    input wire logic tlbValid,
    input wire logic tlbDirty,
    // cache check result
    input wire logic cacheChkErr,
    input wire logic cacheErrDouble,
    input wire logic [1:0] cacheErrWay,
    input wire logic [63:0] cacheErrPaddr,
    // bus completion
    input wire logic busRspValid,
    input wire logic busRspErr,
    // exception outcome
    output logic excTaken,
    output logic [11:0] excVecOffset,
    output logic excVecUncached,
    output logic icacheInvalidate,
    output logic dcacheCorrect,
    output logic irq
);
    tce_pkg::tce_state_t st_q;
    tce_pkg::tce_state_t st_d;

    logic busErr;
    logic take;
    logic isTlb;
    logic isCache;
    logic isBus;
    logic [4:0] selCode;
    logic [11:0] selVec;
    logic setup;
    logic wrAcc;
    logic [7:0] ofs;
    logic [3:0] irqSet;
    logic [63:0] retPc;

    assign busErr = busRspValid & busRspErr; // [RULE14]
    assign setup = psel & ~penable;
    assign wrAcc = psel & penable & pwrite;
    assign ofs = paddr[7:0];
    assign retPc = chkInDelaySlot ? chkBranchPc : chkPc; // [RULE8]

    tce_fault_sel u_sel (
        .mapped(chkMapped),
        .tlbHit(tlbHit),
        .tlbValid(tlbValid),
        .tlbDirty(tlbDirty),
        .addr64(chkAddr64),
        .isFetch(chkIsFetch),
        .isStore(chkIsStore),
        .exception_level_bit(st_q.exception_level_bit),
        .cache_fault_info_reg(cacheChkErr),
        .busErr(busErr),
        .take(take),
        .isTlb(isTlb),
        .isCache(isCache),
        .isBus(isBus),
        .code(selCode),
        .vec(selVec)
    );

    always_comb begin
        st_d = st_q;
        st_d.taken = 1'b0;
        st_d.icInv = 1'b0;
        st_d.dcFix = 1'b0;
        irqSet = 4'h0;
        // register writes
        if (wrAcc) begin
            case (ofs)
                tce_pkg::OFS_STATUS: begin
                    st_d.exception_level_bit = pwdata[tce_pkg::STATUS_EXL_BIT];
                end
                tce_pkg::OFS_IRQ_STAT: begin
                    st_d.irqStat = st_q.irqStat & ~pwdata[3:0];
                end
                tce_pkg::OFS_IRQ_MASK: begin
                    st_d.irqMask = pwdata[3:0];
                end
                default: begin
                end
            endcase
        end
        // exception capture
        if (chkValid && take) begin // [RULE18]
            st_d.taken = 1'b1;
            st_d.exception_level_bit = 1'b1;
            st_d.exception_return_pc = retPc; // [RULE8]
            st_d.bd = chkInDelaySlot; // [RULE8]
            st_d.code = selCode; // [RULE17]
            st_d.lastVec = selVec;
            st_d.uncached = isCache; // [RULE11]
            if (isTlb) begin
                st_d.vaddr = chkVaddr; // [RULE6]
                st_d.ctx = {41'h0, chkVaddr[31:13], 4'h0}; // [RULE6]
                st_d.xctx = {31'h0, chkVaddr[63:62], chkVaddr[39:13], 4'h0}; // [RULE6]
                st_d.tag = {chkVaddr[63:13], 5'h0, curAsid}; // [RULE7]
                irqSet[tce_pkg::IRQ_TLB_BIT] = 1'b1;
            end
            if (isCache) begin
                st_d.cinfo = {cacheErrDouble, ~chkIsFetch, cacheErrWay}; // [RULE12]
                st_d.caddr = chkIsFetch ? chkPc : cacheErrPaddr; // [RULE12]
                st_d.icInv = chkIsFetch; // [RULE13]
                st_d.dcFix = ~chkIsFetch & ~cacheErrDouble; // [RULE13]
                irqSet[tce_pkg::IRQ_CACHE_BIT] = 1'b1;
                irqSet[tce_pkg::IRQ_DOUBLE_BIT] = ~chkIsFetch & cacheErrDouble;
            end
            if (isBus) begin
                irqSet[tce_pkg::IRQ_BUS_BIT] = 1'b1; // [RULE14]
            end
        end
        // set wins over a same-cycle clear
        st_d.irqStat = st_d.irqStat | irqSet;
        // read data latched in setup phase
        st_d.slverr = 1'b0;
        if (setup) begin
            st_d.prdata = 32'h0;
            case (ofs)
                tce_pkg::OFS_STATUS: st_d.prdata[tce_pkg::STATUS_EXL_BIT] = st_q.exception_level_bit;
                tce_pkg::OFS_CAUSE: begin
                    st_d.prdata[tce_pkg::CAUSE_BD_BIT] = st_q.bd;
                    st_d.prdata[tce_pkg::CAUSE_CODE_LSB +: 5] = st_q.code;
                end
                tce_pkg::OFS_EPC_LO: st_d.prdata = st_q.exception_return_pc[31:0];
                tce_pkg::OFS_EPC_HI: st_d.prdata = st_q.exception_return_pc[63:32];
                tce_pkg::OFS_VADDR_LO: st_d.prdata = st_q.vaddr[31:0];
                tce_pkg::OFS_VADDR_HI: st_d.prdata = st_q.vaddr[63:32];
                tce_pkg::OFS_CTX_LO: st_d.prdata = st_q.ctx[31:0];
                tce_pkg::OFS_CTX_HI: st_d.prdata = st_q.ctx[63:32];
                tce_pkg::OFS_XCTX_LO: st_d.prdata = st_q.xctx[31:0];
                tce_pkg::OFS_XCTX_HI: st_d.prdata = st_q.xctx[63:32];
                tce_pkg::OFS_TAG_LO: st_d.prdata = st_q.tag[31:0];
                tce_pkg::OFS_TAG_HI: st_d.prdata = st_q.tag[63:32];
                tce_pkg::OFS_CINFO: st_d.prdata[3:0] = st_q.cinfo;
                tce_pkg::OFS_CADDR_LO: st_d.prdata = st_q.caddr[31:0];
                tce_pkg::OFS_CADDR_HI: st_d.prdata = st_q.caddr[63:32];
                tce_pkg::OFS_IRQ_STAT: st_d.prdata[3:0] = st_q.irqStat;
                tce_pkg::OFS_IRQ_MASK: st_d.prdata[3:0] = st_q.irqMask;
                tce_pkg::OFS_LAST_VEC: st_d.prdata[11:0] = st_q.lastVec;
                default: st_d.slverr = 1'b1;
            endcase
        end else begin
            st_d.slverr = st_q.slverr;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            st_q <= '0;
            st_q.irqMask <= tce_pkg::RST_IRQ_MASK;
            st_q.lastVec <= tce_pkg::RST_LAST_VEC;
        end else begin
            st_q <= st_d;
        end
    end

    // outputs
    assign pready = psel & penable;
    assign prdata = st_q.prdata;
    assign pslverr = st_q.slverr & psel & penable;
    assign excTaken = st_q.taken;
    assign excVecOffset = st_q.lastVec;
    assign excVecUncached = st_q.uncached;
    assign icacheInvalidate = st_q.icInv;
    assign dcacheCorrect = st_q.dcFix;
    assign irq = |(st_q.irqStat & st_q.irqMask);

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    logic fRefill;
    logic fInv;
    logic fMod;
    assign fRefill = chkValid & chkMapped & ~tlbHit;
    assign fInv = chkValid & chkMapped & tlbHit & ~tlbValid;
    assign fMod = chkValid & chkMapped & tlbHit & tlbValid & chkIsStore & ~tlbDirty;

    a_refill_narrow: assert property ( // [RULE2]
        fRefill && !st_q.exception_level_bit && !chkAddr64 |=> excTaken && excVecOffset == 12'h000)
        else $error("refill 32-bit vector wrong");
    a_refill_wide: assert property ( // [RULE3]
        fRefill && !st_q.exception_level_bit && chkAddr64 |=> excTaken && excVecOffset == 12'h080)
        else $error("refill 64-bit vector wrong");
    a_nested_refill: assert property ( // [RULE4]
        fRefill && st_q.exception_level_bit |=> excTaken && excVecOffset == 12'h180 && st_q.exception_level_bit)
        else $error("nested refill not on common vector");
    a_refill_code: assert property ( // [RULE5]
        fRefill |=> st_q.code == (($past(chkIsStore)) ? 5'h03 : 5'h02))
        else $error("refill cause code wrong");
    a_tlb_capture: assert property ( // [RULE6]
        fRefill || fInv || fMod |=> st_q.vaddr == $past(chkVaddr)
            && st_q.ctx[22:4] == $past(chkVaddr[31:13])
            && st_q.xctx[30:4] == $past(chkVaddr[39:13]))
        else $error("faulting address not captured");
    a_tag_address_space_tag: assert property ( // [RULE7]
        fInv |=> st_q.tag[7:0] == $past(curAsid) && st_q.tag[63:13] == $past(chkVaddr[63:13]))
        else $error("address-space tag not captured");
    a_delay_slot: assert property ( // [RULE8]
        fRefill && chkInDelaySlot |=> st_q.bd && st_q.exception_return_pc == $past(chkBranchPc))
        else $error("delay slot return pc wrong");
    a_invalid_fault: assert property ( // [RULE9]
        fInv |=> excTaken && excVecOffset == 12'h180 && st_q.code != 5'h01)
        else $error("invalid fault not reported");
    a_write_protect: assert property ( // [RULE10]
        fMod |=> excTaken && st_q.code == 5'h01 && excVecOffset == 12'h180)
        else $error("write-protect fault wrong");
    a_cache_vector: assert property ( // [RULE11]
        excTaken && st_q.code == 5'h1e |-> excVecOffset == 12'h100 && excVecUncached)
        else $error("cache fault vector wrong");
    a_dcache_fix: assert property ( // [RULE13]
        dcacheCorrect |-> excTaken && !st_q.cinfo[3] && st_q.cinfo[2] && !icacheInvalidate)
        else $error("data correction on wrong error");
    a_bus_code: assert property ( // [RULE15]
        chkValid && busRspValid && busRspErr && !chkMapped && !cacheChkErr
        |=> excTaken && st_q.irqStat[2]
            && st_q.code == (($past(chkIsFetch)) ? 5'h06 : 5'h07))
        else $error("bus fault code wrong");
    a_status_write: assert property (
        psel && penable && pwrite && paddr[7:0] == tce_pkg::OFS_STATUS && !(chkValid && take)
        |=> st_q.exception_level_bit == $past(pwdata[tce_pkg::STATUS_EXL_BIT]))
        else $error("status write lost");

    c_nested: cover property (fRefill && st_q.exception_level_bit ##1 excTaken);
    c_cache_double: cover property (chkValid && cacheChkErr && cacheErrDouble ##1 irq);
    c_bus_fetch: cover property (chkValid && busErr && chkIsFetch ##1 excTaken);
endmodule

// ==== tce_pkg.sv ====
package tce_pkg;
    // apb byte offsets
    localparam logic [7:0] OFS_STATUS = 8'h00;
    localparam logic [7:0] OFS_CAUSE = 8'h04;
    localparam logic [7:0] OFS_EPC_LO = 8'h08;
    localparam logic [7:0] OFS_EPC_HI = 8'h0c;
    localparam logic [7:0] OFS_VADDR_LO = 8'h10;
    localparam logic [7:0] OFS_VADDR_HI = 8'h14;
    localparam logic [7:0] OFS_CTX_LO = 8'h18;
    localparam logic [7:0] OFS_CTX_HI = 8'h1c;
    localparam logic [7:0] OFS_XCTX_LO = 8'h20;
    localparam logic [7:0] OFS_XCTX_HI = 8'h24;
    localparam logic [7:0] OFS_TAG_LO = 8'h28;
    localparam logic [7:0] OFS_TAG_HI = 8'h2c;
    localparam logic [7:0] OFS_CINFO = 8'h30;
    localparam logic [7:0] OFS_CADDR_LO = 8'h34;
    localparam logic [7:0] OFS_CADDR_HI = 8'h38;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h3c;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h40;
    localparam logic [7:0] OFS_LAST_VEC = 8'h44;
    // field positions
    localparam int STATUS_EXL_BIT = 0;
    localparam int CAUSE_BD_BIT = 31;
    localparam int CAUSE_CODE_LSB = 2;
    localparam int IRQ_TLB_BIT = 0;
    localparam int IRQ_CACHE_BIT = 1;
    localparam int IRQ_BUS_BIT = 2;
    localparam int IRQ_DOUBLE_BIT = 3;
    // vector offsets
    localparam logic [11:0] VEC_REFILL32 = 12'h000;
    localparam logic [11:0] VEC_REFILL64 = 12'h080;
    localparam logic [11:0] VEC_CACHE = 12'h100;
    localparam logic [11:0] VEC_COMMON = 12'h180;
    // cause codes
    localparam logic [4:0] CODE_TLB_WRITE_PROTECT = 5'h01;
    localparam logic [4:0] CODE_TLB_LOAD_MISS = 5'h02;
    localparam logic [4:0] CODE_TLB_STORE_MISS = 5'h03;
    localparam logic [4:0] CODE_FETCH_BUS_FAULT = 5'h06;
    localparam logic [4:0] CODE_DATA_BUS_FAULT = 5'h07;
    localparam logic [4:0] CODE_CACHE_FAULT = 5'h1e;
    // reset values
    localparam logic [3:0] RST_IRQ_MASK = 4'h0;
    localparam logic [11:0] RST_LAST_VEC = 12'h000;

    typedef struct packed {
        logic exception_level_bit;
        logic bd;
        logic [4:0] code;
        logic [63:0] exception_return_pc;
        logic [63:0] vaddr;
        logic [63:0] ctx;
        logic [63:0] xctx;
        logic [63:0] tag;
        logic [3:0] cinfo;
        logic [63:0] caddr;
        logic [3:0] irqStat;
        logic [3:0] irqMask;
        logic [11:0] lastVec;
        logic uncached;
        logic taken;
        logic icInv;
        logic dcFix;
        logic [31:0] prdata;
        logic slverr;
    } tce_state_t;
endpackage

// ==== tce_fault_sel.sv ====
`timescale 1ns/1ps
module tce_fault_sel (
    // translation result
    input wire logic mapped,
    input wire logic tlbHit,
    input wire logic tlbValid,
    input wire logic tlbDirty,
    input wire logic addr64,
    // access kind
    input wire logic isFetch,
    input wire logic isStore,
    input wire logic exception_level_bit,
    // other faults
    input wire logic cache_fault_info_reg,
    input wire logic busErr,
    // selection
    output logic take,
    output logic isTlb,
    output logic isCache,
    output logic isBus,
    output logic [4:0] code,
    output logic [11:0] vec
);
    logic refill;
    logic invalid;
    logic modify;
    logic [4:0] missCode;

    assign refill = mapped & ~tlbHit; // [RULE1]
    assign invalid = mapped & tlbHit & ~tlbValid; // [RULE9]
    assign modify = mapped & tlbHit & tlbValid & isStore & ~tlbDirty; // [RULE10]
    assign missCode = isStore ? tce_pkg::CODE_TLB_STORE_MISS : tce_pkg::CODE_TLB_LOAD_MISS; // [RULE5]

    // highest priority fault only
    always_comb begin // [RULE18]
        take = 1'b1;
        isTlb = 1'b0;
        isCache = 1'b0;
        isBus = 1'b0;
        code = missCode;
        vec = tce_pkg::VEC_COMMON; // [RULE16]
        if (refill) begin
            isTlb = 1'b1;
            if (!exception_level_bit) begin // [RULE3]
                vec = addr64 ? tce_pkg::VEC_REFILL64 : tce_pkg::VEC_REFILL32; // [RULE2]
            end
            // nested refill keeps the common vector [RULE4]
        end else if (invalid) begin
            isTlb = 1'b1;
        end else if (modify) begin
            isTlb = 1'b1;
            code = tce_pkg::CODE_TLB_WRITE_PROTECT; // [RULE10]
        end else if (cache_fault_info_reg) begin
            isCache = 1'b1;
            code = tce_pkg::CODE_CACHE_FAULT; // [RULE12]
            vec = tce_pkg::VEC_CACHE; // [RULE11]
        end else if (busErr) begin
            isBus = 1'b1;
            code = isFetch ? tce_pkg::CODE_FETCH_BUS_FAULT : tce_pkg::CODE_DATA_BUS_FAULT; // [RULE15]
        end else begin
            take = 1'b0;
        end
    end
endmodule

// ==== tce_bus_model.sv ====
`timescale 1ns/1ps
module tce_bus_model (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // read request from the core
    input wire logic readReq,
    input wire logic failReq,
    // completion
    output logic busRspValid,
    output logic busRspErr
);
    logic junk_q;
    always_ff @(posedge clk) begin
        junk_q <= srst ? 1'b0 : ~junk_q;
    end
    // completes with the read; error line toggles when idle
    assign busRspValid = readReq;
    assign busRspErr = readReq ? failReq : junk_q;
endmodule

// ==== testbench.sv ====
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin checks++; if ((gt) !== (ex)) begin failures++; \
    $display("[ERR] %s exp %h got %h", nm, ex, gt); end end
module testbench;
    logic clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, lastErr;
    logic [31:0] paddr = 0, pwdata = 0, prdata;
    logic pready, pslverr, chkValid = 0, chkInDelaySlot = 0, chkIsFetch = 0, chkIsStore = 0;
    logic chkAddr64 = 0, chkMapped = 0, tlbHit = 0, tlbValid = 0, tlbDirty = 0, busFail = 0;
    logic cacheChkErr = 0, cacheErrDouble = 0, busRspValid, busRspErr;
    logic [63:0] chkPc = 64'hffff_ffff_8000_0100, chkBranchPc = 64'hffff_ffff_8000_00fc;
    logic [63:0] chkVaddr = 0, cacheErrPaddr = 64'h0000_0001_2345_6780;
    logic [7:0] curAsid = 8'h5a;
    logic [1:0] cacheErrWay = 2'h2;
    logic excTaken, excVecUncached, icacheInvalidate, dcacheCorrect, irq;
    logic [11:0] excVecOffset;
    int failures = 0, checks = 0;
    always #2.5 clk = ~clk;
    tce_bus_model u_bus (.clk(clk), .srst(srst), .readReq(chkValid), .failReq(busFail),
        .busRspValid(busRspValid), .busRspErr(busRspErr));
    tce_exc_unit u_dut (.clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .chkValid(chkValid), .chkPc(chkPc), .chkInDelaySlot(chkInDelaySlot), .chkBranchPc(chkBranchPc),
        .chkIsFetch(chkIsFetch), .chkIsStore(chkIsStore), .chkVaddr(chkVaddr), .chkAddr64(chkAddr64),
        .chkMapped(chkMapped), .curAsid(curAsid), .tlbHit(tlbHit), .tlbValid(tlbValid),
        .tlbDirty(tlbDirty), .cacheChkErr(cacheChkErr), .cacheErrDouble(cacheErrDouble),
        .cacheErrWay(cacheErrWay), .cacheErrPaddr(cacheErrPaddr), .busRspValid(busRspValid),
        .busRspErr(busRspErr), .excTaken(excTaken), .excVecOffset(excVecOffset),
        .excVecUncached(excVecUncached), .icacheInvalidate(icacheInvalidate),
        .dcacheCorrect(dcacheCorrect), .irq(irq));
    task end_of_test;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        int n;
        @(posedge clk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= {24'h0, a}; pwdata <= d;
        @(posedge clk);
        penable <= 1;
        n = 0;
        @(posedge clk);
        while (pready !== 1'b1) begin
            n++;
            if (n > 20) begin
                failures++;
                end_of_test();
            end
            @(posedge clk);
        end
        r = prdata;
        lastErr = pslverr;
        psel <= 0; penable <= 0;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        apb(1'b1, a, d, r);
    endtask
    task rd(input logic [7:0] a, input logic [31:0] ex, input string nm);
        logic [31:0] r;
        apb(1'b0, a, 32'h0, r);
        `CHK(nm, ex, r)
    endtask
    // one instruction check; returns just after the edge that takes it
    task fault(input logic [63:0] va, input logic mp, hit, vld, drt, a64, fe, st, ce, cd, be, ds);
        @(posedge clk);
        chkValid <= 1; chkVaddr <= va; chkMapped <= mp; tlbHit <= hit; tlbValid <= vld;
        tlbDirty <= drt; chkAddr64 <= a64; chkIsFetch <= fe; chkIsStore <= st;
        cacheChkErr <= ce; cacheErrDouble <= cd; busFail <= be; chkInDelaySlot <= ds;
        @(posedge clk);
        chkValid <= 0; cacheChkErr <= 0; busFail <= 0;
        #1;
    endtask
    task expVec(input logic tk, input logic [11:0] v, input logic [4:0] code, input logic bd);
        `CHK("excTaken", tk, excTaken)
        `CHK("excVecOffset", v, excVecOffset)
        rd(tce_pkg::OFS_CAUSE, {bd, 24'h0, code, 2'b00}, "cause");
    endtask
    task t_refill;
        logic [63:0] va;
        va = 64'h0000_0000_1234_5678;
        wr(tce_pkg::OFS_STATUS, 32'h0);
        fault(va, 1, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0);
        expVec(1, tce_pkg::VEC_REFILL32, tce_pkg::CODE_TLB_LOAD_MISS, 0);
        `CHK("uncached", 1'b0, excVecUncached)
        rd(tce_pkg::OFS_EPC_LO, chkPc[31:0], "epc");
        rd(tce_pkg::OFS_VADDR_LO, va[31:0], "vaddr");
        rd(tce_pkg::OFS_CTX_LO, {9'h0, va[31:13], 4'h0}, "ctx");
        rd(tce_pkg::OFS_TAG_LO, {va[31:13], 5'h0, curAsid}, "tag");
        va = 64'h4000_00ab_cdef_2000;
        fault(va, 1, 0, 0, 0, 1, 0, 1, 0, 0, 0, 1);
        expVec(1, tce_pkg::VEC_COMMON, tce_pkg::CODE_TLB_STORE_MISS, 1);
        rd(tce_pkg::OFS_EPC_LO, chkBranchPc[31:0], "epcBranch");
        wr(tce_pkg::OFS_STATUS, 32'h0);
        fault(va, 1, 0, 0, 0, 1, 0, 1, 0, 0, 0, 0);
        expVec(1, tce_pkg::VEC_REFILL64, tce_pkg::CODE_TLB_STORE_MISS, 0);
        rd(tce_pkg::OFS_XCTX_LO, {va[62], va[39:13], 4'h0}, "xctx");
        rd(tce_pkg::OFS_TAG_HI, va[63:32], "tagHi");
        rd(tce_pkg::OFS_VADDR_HI, va[63:32], "vaddrHi");
    endtask
    task t_tlb_other;
        logic [63:0] va;
        va = 64'h0000_0000_0040_3000;
        curAsid <= 8'h3c;
        fault(va, 1, 1, 0, 1, 0, 0, 1, 0, 0, 0, 0);
        expVec(1, tce_pkg::VEC_COMMON, tce_pkg::CODE_TLB_STORE_MISS, 0);
        rd(tce_pkg::OFS_VADDR_LO, va[31:0], "vaddrInv");
        rd(tce_pkg::OFS_TAG_LO, {va[31:13], 5'h0, curAsid}, "tagInv");
        fault(va, 1, 1, 0, 1, 0, 1, 0, 0, 0, 0, 0);
        expVec(1, tce_pkg::VEC_COMMON, tce_pkg::CODE_TLB_LOAD_MISS, 0);
        fault(va, 1, 1, 1, 0, 0, 0, 1, 0, 0, 0, 0);
        expVec(1, tce_pkg::VEC_COMMON, tce_pkg::CODE_TLB_WRITE_PROTECT, 0);
        fault(va, 1, 1, 1, 0, 0, 0, 0, 0, 0, 0, 0);
        `CHK("loadCleanPage", 1'b0, excTaken)
    endtask
    task t_cache;
        fault(64'h0, 0, 0, 0, 0, 0, 1, 0, 1, 0, 0, 0);
        `CHK("icacheInv", 1'b1, icacheInvalidate)
        expVec(1, tce_pkg::VEC_CACHE, tce_pkg::CODE_CACHE_FAULT, 0);
        `CHK("uncachedBase", 1'b1, excVecUncached)
        rd(tce_pkg::OFS_CINFO, {28'h0, 2'b00, cacheErrWay}, "cinfoI");
        rd(tce_pkg::OFS_CADDR_LO, chkPc[31:0], "caddrI");
        fault(64'h0, 0, 0, 0, 0, 0, 0, 0, 1, 0, 0, 0);
        `CHK("dcacheFix", 1'b1, dcacheCorrect)
        `CHK("icacheInvD", 1'b0, icacheInvalidate)
        rd(tce_pkg::OFS_CINFO, {28'h0, 2'b01, cacheErrWay}, "cinfoD");
        rd(tce_pkg::OFS_CADDR_LO, cacheErrPaddr[31:0], "caddrD");
        fault(64'h0, 0, 0, 0, 0, 0, 0, 0, 1, 1, 0, 0);
        `CHK("dcacheDouble", 1'b0, dcacheCorrect)
        rd(tce_pkg::OFS_CINFO, {28'h0, 2'b11, cacheErrWay}, "cinfoDbl");
        rd(tce_pkg::OFS_IRQ_STAT, 32'hb, "irqDouble");
    endtask
    task t_bus;
        fault(64'h0, 0, 0, 0, 0, 0, 1, 0, 0, 0, 1, 0);
        expVec(1, tce_pkg::VEC_COMMON, tce_pkg::CODE_FETCH_BUS_FAULT, 0);
        fault(64'h0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 1, 1);
        expVec(1, tce_pkg::VEC_COMMON, tce_pkg::CODE_DATA_BUS_FAULT, 1);
        fault(64'h0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0);
        `CHK("busOk", 1'b0, excTaken)
    endtask
    task t_priority;
        wr(tce_pkg::OFS_STATUS, 32'h0);
        fault(64'h0000_0000_0000_4000, 1, 0, 0, 0, 0, 1, 0, 1, 0, 1, 0);
        `CHK("noIcacheInv", 1'b0, icacheInvalidate)
        expVec(1, tce_pkg::VEC_REFILL32, tce_pkg::CODE_TLB_LOAD_MISS, 0);
    endtask
    task t_irq;
        wr(tce_pkg::OFS_IRQ_STAT, 32'hf);
        wr(tce_pkg::OFS_IRQ_MASK, 32'h0);
        fault(64'h0, 0, 0, 0, 0, 0, 1, 0, 0, 0, 1, 0);
        rd(tce_pkg::OFS_IRQ_STAT, 32'h4, "irqStat");
        `CHK("irqMasked", 1'b0, irq)
        wr(tce_pkg::OFS_IRQ_MASK, 32'h4);
        @(posedge clk);
        #1;
        `CHK("irqUp", 1'b1, irq)
        wr(tce_pkg::OFS_IRQ_STAT, 32'h4);
        @(posedge clk);
        #1;
        `CHK("irqCleared", 1'b0, irq)
        rd(8'h80, 32'h0, "unmapped");
        `CHK("pslverr", 1'b1, lastErr)
        wr(tce_pkg::OFS_CAUSE, 32'hffff_ffff);
        rd(tce_pkg::OFS_CAUSE, {1'b0, 24'h0, tce_pkg::CODE_FETCH_BUS_FAULT, 2'b00}, "causeRo");
    endtask
    initial begin
        repeat (10) @(posedge clk);
        srst <= 0;
        #1;
        `CHK("rstVec", 12'h000, excVecOffset)
        rd(tce_pkg::OFS_IRQ_MASK, {28'h0, tce_pkg::RST_IRQ_MASK}, "rstMask");
        t_refill();
        t_tlb_other();
        t_cache();
        t_bus();
        t_priority();
        t_irq();
        end_of_test();
    end
endmodule
